// >>> eac_top.sv
// Energy accumulation mode configuration: wiring selection, reverse-power flags,
// line-cycle timing and read-with-reset of twelve energy accumulators.
// Assumes samples, rms values and zero-crossing pulses arrive from the DSP on pclk.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps

module eac_top
    import eac_pkg::*;
#(
    parameter int SW = 15,
    parameter int LC_COUNT = LC_COUNT_DEFAULT
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Instantaneous samples, phase C in the top slice.
    input wire logic sample_valid,
    input wire logic [2:0][SW-1:0] phase_voltage,
    input wire logic [2:0][SW-1:0] phase_current,
    input wire logic [2:0][SW-1:0] phase_current_shifted,
    // Rms values.
    input wire logic [2:0][SW-1:0] phase_voltage_rms,
    input wire logic [2:0][SW-1:0] phase_current_rms,
    // Fundamental powers.
    input wire logic [2:0][DATA_W-1:0] fund_active_power,
    input wire logic [2:0][DATA_W-1:0] fund_reactive_power,
    // Zero-crossing pulses.
    input wire logic [2:0] zero_cross,
    // Interrupt.
    output logic irq
);

    localparam int VW = SW + 2;
    localparam int PW = VW + SW;
    localparam logic [LC_CNT_W-1:0] LC_LIMIT = LC_COUNT[LC_CNT_W-1:0];

    // ==========================================================
    // Configuration and status registers.
    logic [7:0] acc_mode_q, acc_mode_d;
    logic [7:0] line_cycle_q, line_cycle_d;
    logic [31:0] primary_status_word_q, primary_status_word_d;
    logic [31:0] mask_q, mask_d;
    logic [DATA_W-1:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;

    eac_wiring_t wiring_input_select;
    logic rev_active_source_sel;
    logic rev_reactive_source_sel;
    logic active_line_cycle_en;
    logic reactive_line_cycle_en;
    logic apparent_line_cycle_en;
    logic zero_cross_phase_a_en;
    logic zero_cross_phase_b_en;
    logic zero_cross_phase_c_en;
    logic clear_on_read_en;

    // Field extraction; bit 7 of the line-cycle register is never stored.
    assign wiring_input_select = eac_wiring_t'(acc_mode_q[WIRING_LSB +: 2]);
    assign rev_active_source_sel = acc_mode_q[REV_ACT_SEL_BIT];
    assign rev_reactive_source_sel = acc_mode_q[REV_REACT_SEL_BIT];
    assign active_line_cycle_en = line_cycle_q[ACTIVE_LC_BIT];
    assign reactive_line_cycle_en = line_cycle_q[REACTIVE_LC_BIT];
    assign apparent_line_cycle_en = line_cycle_q[APPARENT_LC_BIT];
    assign zero_cross_phase_a_en = line_cycle_q[ZX_LSB];
    assign zero_cross_phase_b_en = line_cycle_q[ZX_LSB + 1];
    assign zero_cross_phase_c_en = line_cycle_q[ZX_LSB + 2];
    assign clear_on_read_en = line_cycle_q[CLEAR_ON_READ_BIT];

    // ==========================================================
    // Wiring selection of the voltages feeding the products.
    logic signed [VW-1:0] volt_eff [3];
    logic phase_b_off;
    logic signed [VW-1:0] va_x;
    logic signed [VW-1:0] vc_x;

    always_comb begin
        va_x = VW'($signed(phase_voltage[0]));
        vc_x = VW'($signed(phase_voltage[2]));
        volt_eff[0] = va_x;
        volt_eff[2] = vc_x;
        volt_eff[1] = VW'($signed(phase_voltage[1]));
        phase_b_off = 1'b0;
        case (wiring_input_select)
            EAC_WYE_3V: begin
                volt_eff[1] = VW'($signed(phase_voltage[1]));
            end
            EAC_DELTA_3W: begin
                phase_b_off = 1'b1;
            end
            EAC_WYE_2V: begin
                volt_eff[1] = -va_x - vc_x;
            end
            EAC_DELTA_4W: begin
                volt_eff[1] = -va_x;
            end
            default: begin
                volt_eff[1] = VW'($signed(phase_voltage[1]));
            end
        endcase
    end

    // ==========================================================
    // Per-phase products and accumulator addends.
    logic signed [DATA_W-1:0] addend [NUM_ENERGY];
    logic signed [DATA_W-1:0] total_active [3];
    logic signed [DATA_W-1:0] total_reactive [3];
    logic [DATA_W-1:0] energy_value [NUM_ENERGY];
    logic [NUM_ENERGY-1:0] read_clear;
    logic [NUM_ENERGY-1:0] lc_mode;
    logic period_end_q, period_end_d;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_phase
            logic signed [PW-1:0] p_act;
            logic signed [PW-1:0] p_react;
            logic [2*SW-1:0] p_app;
            logic off;
            assign off = (g == 1) && phase_b_off;
            assign p_act = volt_eff[g] * PW'($signed(phase_current[g]));
            // Shifted current gives the reactive product in every wiring mode.
            assign p_react = volt_eff[g] * PW'($signed(phase_current_shifted[g]));
            assign p_app = phase_voltage_rms[g] * phase_current_rms[g];
            assign total_active[g] = off ? '0 : DATA_W'(p_act);
            assign total_reactive[g] = off ? '0 : DATA_W'(p_react);
            assign addend[CH_ACT + g] = total_active[g];
            assign addend[CH_FACT + g] = off ? '0 : $signed(fund_active_power[g]);
            assign addend[CH_REACT + g] = total_reactive[g];
            assign addend[CH_APP + g] = off ? '0 : $signed(DATA_W'(p_app));
            assign lc_mode[CH_ACT + g] = active_line_cycle_en;
            assign lc_mode[CH_FACT + g] = active_line_cycle_en;
            assign lc_mode[CH_REACT + g] = reactive_line_cycle_en;
            assign lc_mode[CH_APP + g] = apparent_line_cycle_en;
        end
        for (g = 0; g < NUM_ENERGY; g++) begin : g_energy
            eac_accum #(
                .AW(DATA_W)
            ) u_accum (
                .pclk(pclk),
                .presetn(presetn),
                .sample_valid(sample_valid),
                .addend(addend[g]),
                .line_cycle(lc_mode[g]),
                .period_end(period_end_q),
                .read_clear(read_clear[g]),
                .value(energy_value[g])
            );
        end
    endgenerate

    // ==========================================================
    // Line-cycle period timing from the enabled zero crossings.
    logic [LC_CNT_W-1:0] lc_cnt_q, lc_cnt_d;
    logic [1:0] zx_hits;
    logic [LC_CNT_W-1:0] lc_sum;

    // Every enabled phase adds its crossing, so more phases give a shorter period.
    always_comb begin
        zx_hits = {1'b0, zero_cross[0] & zero_cross_phase_a_en}
                + {1'b0, zero_cross[1] & zero_cross_phase_b_en}
                + {1'b0, zero_cross[2] & zero_cross_phase_c_en};
        lc_sum = lc_cnt_q + LC_CNT_W'(zx_hits);
        lc_cnt_d = lc_sum;
        period_end_d = 1'b0;
        if (lc_sum >= LC_LIMIT) begin
            lc_cnt_d = '0;
            period_end_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_cnt_q <= '0;
            period_end_q <= 1'b0;
        end else begin
            lc_cnt_q <= lc_cnt_d;
            period_end_q <= period_end_d;
        end
    end

    // ==========================================================
    // Reverse-power sign tracking; a status bit is raised on each sign change.
    logic [5:0] sign_q, sign_d;
    logic [5:0] sign_now;
    logic [5:0] sign_event;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            sign_now[i] = rev_active_source_sel ? fund_active_power[i][DATA_W-1]
                                                : total_active[i][DATA_W-1];
            sign_now[3 + i] = rev_reactive_source_sel ? fund_reactive_power[i][DATA_W-1]
                                                      : total_reactive[i][DATA_W-1];
        end
        sign_d = sample_valid ? sign_now : sign_q;
        sign_event = sample_valid ? (sign_now ^ sign_q) : 6'h00;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sign_q <= 6'h00;
        end else begin
            sign_q <= sign_d;
        end
    end

    // ==========================================================
    // APB decode. The answer comes one cycle after setup, so every
    // transfer is exactly setup plus one access cycle.
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] energy_off;
    logic aligned;
    logic setup;
    logic done;
    logic hit_energy;
    logic hit_any;
    logic [31:0] status_set;
    logic [31:0] status_clr;

    assign idx = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign energy_off = idx - IDX_ENERGY_BASE;
    assign setup = psel && !penable;
    assign done = psel && penable && pready_q;
    assign hit_energy = aligned && (energy_off < IDX_W'(NUM_ENERGY));
    assign hit_any = hit_energy || (aligned && ((idx == IDX_ACC_MODE)
                     || (idx == IDX_LINE_CYCLE) || (idx == IDX_STATUS) || (idx == IDX_MASK)));

    // Clear pulses for the accumulator read at the completing edge.
    always_comb begin
        read_clear = '0;
        if (done && !pwrite && hit_energy && clear_on_read_en) begin
            read_clear[energy_off[3:0]] = 1'b1;
        end
    end

    // ==========================================================
    // Register file, response and interrupt next values.
    always_comb begin
        acc_mode_d = acc_mode_q;
        line_cycle_d = line_cycle_q;
        mask_d = mask_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        pready_d = setup;
        status_clr = 32'h0000_0000;
        status_set = 32'h0000_0000;
        status_set[ST_REV_ACT_LSB +: 3] = sign_event[2:0];
        status_set[ST_REV_REACT_LSB +: 3] = sign_event[5:3];
        status_set[ST_LINE_CYCLE_DONE] = period_end_q;
        if (setup) begin
            pslverr_d = !hit_any;
            prdata_d = 32'h0000_0000;
            if (!pwrite) begin
                if (hit_energy) begin
                    prdata_d = energy_value[energy_off[3:0]];
                end else if (idx == IDX_ACC_MODE) begin
                    prdata_d = {24'h00_0000, acc_mode_q};
                end else if (idx == IDX_LINE_CYCLE) begin
                    prdata_d = {24'h00_0000, line_cycle_q};
                end else if (idx == IDX_STATUS) begin
                    prdata_d = primary_status_word_q;
                end else if (idx == IDX_MASK) begin
                    prdata_d = mask_q;
                end
            end
        end
        if (done && pwrite && aligned) begin
            if (idx == IDX_ACC_MODE) begin
                acc_mode_d = pwdata[7:0];
            end
            if (idx == IDX_LINE_CYCLE) begin
                line_cycle_d = pwdata[7:0] & LINE_CYCLE_WR_MASK;
            end
            if (idx == IDX_STATUS) begin
                status_clr = pwdata & STATUS_USED;
            end
            if (idx == IDX_MASK) begin
                mask_d = pwdata & STATUS_USED;
            end
        end
        // Set beats clear so an event in the clearing cycle survives.
        primary_status_word_d = ((primary_status_word_q & ~status_clr) | status_set)
                                & STATUS_USED;
        irq_d = |(primary_status_word_d & mask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_mode_q <= ACC_MODE_RST;
            line_cycle_q <= LINE_CYCLE_RST;
            primary_status_word_q <= 32'h0000_0000;
            mask_q <= MASK_RST;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            acc_mode_q <= acc_mode_d;
            line_cycle_q <= line_cycle_d;
            primary_status_word_q <= primary_status_word_d;
            mask_q <= mask_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
        end
    end

    // All outputs come straight from registers.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

endmodule

// >>> eac_pkg.sv
// Constants, field layouts and reset values of the energy accumulation mode block.
// Assumes an APB slave with 32-bit data; the bus master adds the byte offset itself.
//
// Behaviour
// - Wiring code 00 makes every phase use its own voltage and current for active and reactive energy.
// - Wiring code 01 forces the phase B active, reactive and apparent inputs to zero.
// - Wiring code 10 forms phase B voltage as minus phase A voltage minus phase C voltage.
// - Wiring code 11 forms phase B voltage as the negated phase A voltage.
// - Reactive products use each phase current shifted by minus ninety degrees.
// - Apparent energy accumulates rms voltage times rms current, zero on phase B only for 01.
// - The active source select bit picks total or fundamental power for status bits 6 to 8.
// - The reactive source select bit picks total or fundamental power for status bits 10 to 12.
// - Control bit 0 puts all active accumulators in line-cycle mode when set.
// - Control bit 1 puts the reactive accumulators in line-cycle mode when set.
// - Control bit 2 puts the apparent accumulators in line-cycle mode when set.
// - Bits 3 to 5 enable zero-crossing counting for phases A to C and reset to one.
// - Crossings of all enabled phases advance the count, so the period shortens.
// - With bit 6 set, reading an energy accumulator returns its value and clears it.
// - Bit 7 of the line-cycle control register is reserved and does nothing.

package eac_pkg;

    // ==========================================================
    // Bus geometry.
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int IDX_W = 16;

    // ==========================================================
    // Register indices; byte address is four times the index.
    localparam logic [IDX_W-1:0] IDX_ACC_MODE = 16'hE701;
    localparam logic [IDX_W-1:0] IDX_LINE_CYCLE = 16'hE702;
    localparam logic [IDX_W-1:0] IDX_STATUS = 16'hE800;
    localparam logic [IDX_W-1:0] IDX_MASK = 16'hE801;
    localparam logic [IDX_W-1:0] IDX_ENERGY_BASE = 16'hE400;

    // ==========================================================
    // Reset values and writable masks.
    localparam logic [7:0] ACC_MODE_RST = 8'h00;
    localparam logic [7:0] LINE_CYCLE_RST = 8'h78;
    localparam logic [7:0] LINE_CYCLE_WR_MASK = 8'h7F;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;

    // ==========================================================
    // Field positions.
    localparam int WIRING_LSB = 4;
    localparam int REV_ACT_SEL_BIT = 6;
    localparam int REV_REACT_SEL_BIT = 7;
    localparam int ACTIVE_LC_BIT = 0;
    localparam int REACTIVE_LC_BIT = 1;
    localparam int APPARENT_LC_BIT = 2;
    localparam int ZX_LSB = 3;
    localparam int CLEAR_ON_READ_BIT = 6;

    // ==========================================================
    // Status word layout.
    localparam int ST_REV_ACT_LSB = 6;
    localparam int ST_REV_REACT_LSB = 10;
    localparam int ST_LINE_CYCLE_DONE = 18;
    localparam logic [31:0] STATUS_USED = 32'h0004_1DC0;

    // ==========================================================
    // Energy channel numbering: four groups of three phases.
    localparam int NUM_ENERGY = 12;
    localparam int CH_ACT = 0;
    localparam int CH_FACT = 3;
    localparam int CH_REACT = 6;
    localparam int CH_APP = 9;

    // Default number of counted zero crossings per line-cycle period.
    localparam int LC_COUNT_DEFAULT = 100;
    localparam int LC_CNT_W = 16;

    // Wiring topology codes.
    typedef enum logic [1:0] {
        EAC_WYE_3V = 2'h0,
        EAC_DELTA_3W = 2'h1,
        EAC_WYE_2V = 2'h2,
        EAC_DELTA_4W = 2'h3
    } eac_wiring_t;

endpackage

// >>> eac_accum.sv
// One energy accumulator with regular and line-cycle modes and read-with-reset.
// Assumes addend and control pulses come from logic on the same clock.
`timescale 1ns/1ps

module eac_accum
    import eac_pkg::*;
#(
    parameter int AW = 32
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Datapath.
    input wire logic sample_valid,
    input wire logic signed [AW-1:0] addend,
    // Control.
    input wire logic line_cycle,
    input wire logic period_end,
    input wire logic read_clear,
    // Readable result.
    output logic [AW-1:0] value
);

    logic signed [AW-1:0] work_q, work_d;
    logic signed [AW-1:0] result_q, result_d;
    logic signed [AW-1:0] inc;

    // ==========================================================
    // Next-value logic. A sample arriving with a clear is kept, so no energy is lost.
    always_comb begin
        inc = sample_valid ? addend : '0;
        work_d = work_q;
        result_d = result_q;
        if (line_cycle) begin
            work_d = work_q + inc;
            if (read_clear) begin
                result_d = '0;
            end
            if (period_end) begin
                result_d = work_q + inc;
                work_d = '0;
            end
        end else begin
            // Regular mode: the readable value is the running sum itself.
            result_d = (read_clear ? '0 : result_q) + inc;
            work_d = '0;
        end
    end

    // ==========================================================
    // State registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_q <= '0;
            result_q <= '0;
        end else begin
            work_q <= work_d;
            result_q <= result_d;
        end
    end

    assign value = result_q;

endmodule

// >>> eac_top_chk.sv
// Checker for the energy accumulation mode block, bound to its top module.
// Assumes APB answers in one access cycle and irq is registered from status and mask.
`timescale 1ns/1ps

module eac_top_chk
    import eac_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt.
    input wire logic irq
);
    // =====
    // Shadow copies of the two mode registers.
    logic [7:0] acc_q, acc_d, lc_q, lc_d;
    wire setup = psel && !penable;
    wire done = psel && penable && pready;
    wire rd = done && !pwrite;
    wire acc_wr = done && pwrite && paddr == {IDX_ACC_MODE, 2'b00};
    wire lc_wr = done && pwrite && paddr == {IDX_LINE_CYCLE, 2'b00};

    // Reserved bit 7 is masked here so a stale write can never read back.
    always_comb begin
        acc_d = acc_wr ? pwdata[7:0] : acc_q;
        lc_d = lc_wr ? (pwdata[7:0] & LINE_CYCLE_WR_MASK) : lc_q;
    end

    // Shadow registers follow completed writes only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= ACC_MODE_RST;
            lc_q <= LINE_CYCLE_RST;
        end else begin
            acc_q <= acc_d;
            lc_q <= lc_d;
        end
    end

    // =====
    // Assertions.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READY: assert property (setup |=> pready)
        else $error("no access answer after setup");
    AST_READY_CAUSE: assert property (pready |-> $past(setup))
        else $error("ready without setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    AST_UNALIGNED: assert property (done && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access accepted");
    AST_ACC_RB: assert property (rd && paddr == {IDX_ACC_MODE, 2'b00} |-> prdata == {24'h0, acc_q})
        else $error("mode register readback wrong");
    AST_LC_RB: assert property (rd && paddr == {IDX_LINE_CYCLE, 2'b00} |-> prdata == {24'h0, lc_q})
        else $error("line cycle readback wrong");
    AST_RSVD: assert property (rd && paddr == {IDX_LINE_CYCLE, 2'b00} |-> !prdata[7])
        else $error("reserved bit reads one");
    AST_IRQ_MASK: assert property (done && pwrite && paddr == {IDX_MASK, 2'b00} && pwdata == 32'h0 |=> ##1 !irq)
        else $error("irq high with empty mask");

    COV_WRITE: cover property (setup ##1 pready && pwrite);
    COV_ERR: cover property (rd && pslverr);
    COV_IRQ: cover property ($rose(irq));
endmodule

bind eac_top eac_top_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

// >>> tb.sv
// Self-checking bench for the energy accumulation mode block.
// Assumes a one-cycle APB answer and a line-cycle count shortened to four.
`timescale 1ns/1ps

module tb
    import eac_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0;
    logic pready, pslverr, irq, err;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [2:0][14:0] v = '0, ci = '0, cs = '0, vr = '0, ir = '0;
    logic [2:0][31:0] fa = '0, fr = '0;
    logic [2:0] zc = 0;
    logic [15:0] sd = 16'h005B;
    int failures = 0, compares = 0;

    eac_top #(.LC_COUNT(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid), .phase_voltage(v), .phase_current(ci),
        .phase_current_shifted(cs), .phase_voltage_rms(vr), .phase_current_rms(ir),
        .fund_active_power(fa), .fund_reactive_power(fr), .zero_cross(zc), .irq(irq));

    // =====
    // Clock.
    always #2.5 pclk = ~pclk;

    // Values kept to 12 bits so four periods of products stay inside 32 bits.
    function automatic logic [14:0] nxt();
        sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
        return {{3{sd[11]}}, sd[11:0]};
    endfunction

    function automatic logic [17:0] ad(logic [15:0] i);
        return {i, 2'b00};
    endfunction

    // Reference product of one energy channel for a wiring code.
    function automatic int model(int ch, int code);
        int p, vp;
        p = ch % 3;
        vp = $signed(v[p]);
        if (p == 1 && code == 2) vp = -$signed(v[0]) - $signed(v[2]);
        if (p == 1 && code == 3) vp = -$signed(v[0]);
        if (p == 1 && code == 1) return 0;
        if (ch < 3) return vp * $signed(ci[p]);
        if (ch < 6) return $signed(fa[p]);
        if (ch < 9) return vp * $signed(cs[p]);
        return int'(vr[p]) * int'(ir[p]);
    endfunction

    // =====
    // Checking and closing.
    task automatic chk(logic [31:0] s, logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic complete_run();
        if (failures == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; the wait is bounded so a dead slave ends the run.
    task automatic apb(logic w, logic [17:0] a, logic [31:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            complete_run();
        end
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    // =====
    // Stimulus helpers.
    task automatic rnd();
        for (int k = 0; k < 3; k++) begin
            v[k] <= nxt();
            ci[k] <= nxt();
            cs[k] <= nxt();
            vr[k] <= nxt() & 15'h0FFF;
            ir[k] <= nxt() & 15'h0FFF;
            fa[k] <= 32'h5;
            fr[k] <= 32'h5;
        end
        @(posedge pclk);
    endtask

    task automatic smp(int n);
        sample_valid <= 1;
        repeat (n) @(posedge pclk);
        sample_valid <= 0;
        @(posedge pclk);
    endtask

    task automatic zx(logic [2:0] m);
        zc <= m;
        @(posedge pclk);
        zc <= 0;
        repeat (2) @(posedge pclk);
    endtask

    // Reads every channel twice; the second read expects zero when cor is set, else the same value.
    task automatic energy(int mult, int code, logic cor);
        for (int ch = 0; ch < 12; ch++) begin
            apb(0, ad(IDX_ENERGY_BASE + 16'(ch)), 0);
            chk(r, 32'(mult * model(ch, code)));
            apb(0, ad(IDX_ENERGY_BASE + 16'(ch)), 0);
            chk(r, cor ? 32'h0 : 32'(mult * model(ch, code)));
        end
    endtask

    // Flips fundamental powers with totals held, then reads the reverse flags.
    task automatic flag(logic [7:0] m, logic [31:0] e);
        apb(1, ad(IDX_ACC_MODE), {24'h0, m});
        smp(1);
        apb(1, ad(IDX_STATUS), 32'h1DC0);
        fa[0] <= -fa[0];
        fr[2] <= -fr[2];
        smp(1);
        apb(0, ad(IDX_STATUS), 0);
        chk(r & 32'h1DC0, e);
    endtask

    // =====
    // Main sequence.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, ad(IDX_ACC_MODE), 0);
        chk(r, 32'h0);
        apb(0, ad(IDX_LINE_CYCLE), 0);
        chk(r, 32'h78);
        apb(1, ad(IDX_LINE_CYCLE), 32'hFF);
        apb(0, ad(IDX_LINE_CYCLE), 0);
        chk(r, 32'h7F);
        apb(0, ad(IDX_ACC_MODE) + 18'h2, 0);
        chk({r[30:0], err}, 32'h1);
        apb(1, ad(IDX_LINE_CYCLE), 32'h78);
        // Every wiring code with fresh samples.
        for (int c = 0; c < 4; c++) begin
            apb(1, ad(IDX_ACC_MODE), 32'(c << 4));
            rnd();
            for (int k = 0; k < 12; k++) apb(0, ad(IDX_ENERGY_BASE + 16'(k)), 0);
            smp(2);
            energy(2, c, 1);
        end
        apb(1, ad(IDX_LINE_CYCLE), 32'h38);
        smp(1);
        energy(1, 3, 0);
        // Line cycle on phase A only; B and C crossings must not count.
        apb(1, ad(IDX_LINE_CYCLE), 32'h0F);
        repeat (4) zx(3'h1);
        smp(3);
        zx(3'h2);
        zx(3'h4);
        repeat (3) zx(3'h1);
        smp(1);
        zx(3'h1);
        repeat (4) @(posedge pclk);
        chk(irq, 1'b0);
        energy(4, 3, 0);
        apb(0, ad(IDX_STATUS), 0);
        chk(r & 32'h40000, 32'h40000);
        apb(1, ad(IDX_MASK), 32'h40000);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1, ad(IDX_STATUS), 32'h40000);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        // All phases enabled: mixed crossings share one count.
        apb(1, ad(IDX_LINE_CYCLE), 32'h3F);
        smp(2);
        zx(3'h1);
        zx(3'h2);
        zx(3'h4);
        zx(3'h1);
        repeat (4) @(posedge pclk);
        energy(2, 3, 0);
        apb(1, ad(IDX_MASK), 32'h0);
        apb(1, ad(IDX_LINE_CYCLE), 32'h78);
        flag(8'hC0, 32'h1040);
        flag(8'h00, 32'h0);
        complete_run();
    end
endmodule
